// ### rtl/pcstack_pkg.sv
// shared constants and types for the program counter and return stack
package pcstack_pkg;
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam int STACK_DEPTH = 31;
  localparam logic [20:0] RESET_VECTOR = 21'h000000;
  localparam logic [20:0] HIGH_VECTOR = 21'h000008;
  localparam logic [20:0] LOW_VECTOR = 21'h000018;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] MEM_TOP_DEFAULT = 21'h007FFF;
  // register offsets on the plain register port
  localparam logic [3:0] REG_SP = 4'h0;
  localparam logic [3:0] REG_TOS_LOW = 4'h1;
  localparam logic [3:0] REG_TOS_HIGH = 4'h2;
  localparam logic [3:0] REG_TOS_UPPER = 4'h3;
  localparam logic [3:0] REG_PC_LOW = 4'h4;
  localparam logic [3:0] REG_PC_HIGH_LATCH = 4'h5;
  localparam logic [3:0] REG_PC_UPPER_LATCH = 4'h6;
  // stack pointer register fields
  localparam int FULL_BIT = 7;
  localparam int UNDER_BIT = 6;
  localparam logic [7:0] SP_REG_RESET = 8'h00;
  localparam logic [4:0] SP_MAX = 5'h1F;
  // core operations
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_STEP = 4'h1,
    OP_CALL = 4'h2,
    OP_JUMP = 4'h3,
    OP_RETURN = 4'h4,
    OP_PUSH = 4'h5,
    OP_POP = 4'h6,
    OP_INT_HIGH = 4'h7,
    OP_INT_LOW = 4'h8
  } core_op_t;
endpackage

// ### rtl/stack_ram_if.sv
// port bundle between the control logic and the return stack storage
interface stack_ram_if;
  logic we;
  logic [4:0] waddr;
  logic [20:0] wdata;
  logic [4:0] raddr;
  logic [20:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr,
    input rdata);
  modport ram (input we, input waddr, input wdata, input raddr,
    output rdata);
endinterface

// ### rtl/stack_ram.sv
// 31 by 21 return stack storage in flip-flops, entry 0 absent
module stack_ram
  import pcstack_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  stack_ram_if.ram bus
);
  typedef struct packed {
    logic [STACK_DEPTH:1][PC_W-1:0] mem;
  } ram_state_t;
  ram_state_t s_r;
  ram_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (bus.we && bus.waddr != 5'h00) begin
      s_nxt.mem[bus.waddr] = bus.wdata;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // pointer zero has no storage and reads as zero
  assign bus.rdata = (bus.raddr == 5'h00) ? 21'h000000 :
    s_r.mem[bus.raddr];
endmodule

// ### rtl/pc_return_stack.sv
// program counter, return address stack and fast shadow stack
// How it works
// - 21-bit counter; fetch above implemented memory reads as zero (NOP).
// - reset starts at 0000h; interrupts vector to 0008h or 0018h.
// - 31 entries of 21 bits, 5-bit pointer cleared by reset, zero empty.
// - call or interrupt increments pointer, then writes counter there.
// - return loads counter from selected entry, then decrements pointer.
// - calls and returns leave both latch registers untouched.
// - three top-of-stack byte registers read and write the selected entry.
// - software reads and writes the pointer, values 0 to 31.
// - full flag sets on 31st push; cleared only by software or power-on.
// - fault reset on: 31st push stores counter plus two, flags, resets.
// - fault reset off: pointer goes to 31, later pushes ignored.
// - pop at zero loads zero, sets underflow, pointer stays zero.
// - underflow with fault reset enabled also resets the device.
// - pointer register: bit7 full, bit6 underflow, bit5 zero, bits 4-0.
// - push stores counter after increment; pop only decrements.
// - shadow of status, working, bank select loaded on any interrupt.
// - fast return restores shadow; fast call loads shadow.
// - high interrupt during low service overwrites the single shadow.
// - counter low byte accessible; upper bytes only through latches.
// - bit 0 always zero; sequential step is 2.
// - calls, jumps and branches load counter directly, no latches.
// - low byte write loads upper bytes from latches; read fills latches.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
module pc_return_stack
  import pcstack_pkg::*;
#(
  parameter logic [20:0] MEM_TOP = MEM_TOP_DEFAULT
)
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic por_in,
  input wire logic fault_reset_enable_in,
  input wire logic [3:0] op_in,
  input wire logic [20:0] target_in,
  input wire logic fast_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] working_in,
  input wire logic [7:0] bank_in,
  input wire logic [15:0] fetch_data_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic [20:0] pc_out,
  output logic [15:0] fetch_word_out,
  output logic stack_reset_out,
  output logic restore_out,
  output logic [7:0] status_out,
  output logic [7:0] working_out,
  output logic [7:0] bank_out
);
  typedef struct packed {
    logic [20:0] pc;
    logic [7:0] high_latch;
    logic [4:0] upper_latch;
    logic [4:0] sp;
    logic full;
    logic under;
    logic [7:0] sh_status;
    logic [7:0] sh_working;
    logic [7:0] sh_bank;
    logic [7:0] rdata;
    logic [15:0] fetch;
    logic fault;
    logic restore;
    logic [7:0] status_o;
    logic [7:0] working_o;
    logic [7:0] bank_o;
  } state_t;
  state_t s_r;
  state_t s_nxt;
  stack_ram_if ram_bus ();
  logic [4:0] sp_new;
  logic push;
  logic pop;
  logic is_call;
  logic is_int;
  logic is_ret;
  logic [20:0] tos_val;
  logic [20:0] wentry;
  logic wentry_we;

  stack_ram u_ram (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .bus(ram_bus)
  );

  always_comb begin
    is_int = (op_in == OP_INT_HIGH) || (op_in == OP_INT_LOW);
    is_call = (op_in == OP_CALL);
    is_ret = (op_in == OP_RETURN);
    push = is_call || is_int || (op_in == OP_PUSH);
    pop = is_ret || (op_in == OP_POP);
  end

  // new pointer addresses top-of-stack writes; register reads this cycle see the old pointer
  always_comb begin
    sp_new = s_r.sp;
    if (push && s_r.sp != SP_MAX) begin
      sp_new = s_r.sp + 5'h01;
    end else if (pop && s_r.sp != 5'h00) begin
      sp_new = s_r.sp - 5'h01;
    end
  end

  assign ram_bus.raddr = s_r.sp;
  assign tos_val = ram_bus.rdata;

  always_comb begin
    s_nxt = s_r;
    wentry = s_r.pc;
    wentry_we = 1'b0;
    s_nxt.fault = 1'b0;
    s_nxt.restore = 1'b0;
    s_nxt.rdata = 8'h00;
    // stack operations
    if (push) begin
      if (s_r.sp != SP_MAX) begin
        wentry_we = 1'b1;
        if (s_r.sp == SP_MAX - 5'h01) begin
          s_nxt.full = 1'b1;
          if (fault_reset_enable_in) begin
            wentry = s_r.pc + PC_STEP;
            s_nxt.fault = 1'b1;
          end
        end
      end else begin
        s_nxt.full = 1'b1;
      end
    end
    if (pop && s_r.sp == 5'h00) begin
      s_nxt.under = 1'b1;
      if (fault_reset_enable_in) begin
        s_nxt.fault = 1'b1;
      end
    end
    s_nxt.sp = sp_new;
    // program counter sequencing; latches untouched here
    unique case (op_in)
      OP_STEP, OP_PUSH, OP_POP: begin
        s_nxt.pc = s_r.pc + PC_STEP;
      end
      OP_CALL, OP_JUMP: begin
        s_nxt.pc = {target_in[20:1], 1'b0};
      end
      OP_RETURN: begin
        s_nxt.pc = (s_r.sp == 5'h00) ? 21'h000000 :
          {tos_val[20:1], 1'b0};
      end
      OP_INT_HIGH: begin
        s_nxt.pc = HIGH_VECTOR;
      end
      OP_INT_LOW: begin
        s_nxt.pc = LOW_VECTOR;
      end
      default: begin
        s_nxt.pc = s_r.pc;
      end
    endcase
    // shadow stack, single level
    if (is_int || (is_call && fast_in)) begin
      s_nxt.sh_status = status_in;
      s_nxt.sh_working = working_in;
      s_nxt.sh_bank = bank_in;
    end
    if (is_ret && fast_in) begin
      s_nxt.restore = 1'b1;
    end
    s_nxt.status_o = s_r.sh_status;
    s_nxt.working_o = s_r.sh_working;
    s_nxt.bank_o = s_r.sh_bank;
    // register writes; top-of-stack writes hit the new entry
    if (wr_in) begin
      unique case (addr_in)
        REG_SP: begin
          s_nxt.sp = wdata_in[4:0];
          s_nxt.full = s_r.full & wdata_in[FULL_BIT];
          s_nxt.under = s_r.under & wdata_in[UNDER_BIT];
        end
        REG_TOS_LOW: begin
          wentry = wentry_we ? wentry : tos_val;
          wentry[7:0] = wdata_in;
          wentry_we = 1'b1;
        end
        REG_TOS_HIGH: begin
          wentry = wentry_we ? wentry : tos_val;
          wentry[15:8] = wdata_in;
          wentry_we = 1'b1;
        end
        REG_TOS_UPPER: begin
          wentry = wentry_we ? wentry : tos_val;
          wentry[20:16] = wdata_in[4:0];
          wentry_we = 1'b1;
        end
        REG_PC_LOW: begin
          s_nxt.pc = {s_r.upper_latch, s_r.high_latch,
            wdata_in[7:1], 1'b0};
        end
        REG_PC_HIGH_LATCH: begin
          s_nxt.high_latch = wdata_in;
        end
        REG_PC_UPPER_LATCH: begin
          s_nxt.upper_latch = wdata_in[4:0];
        end
        default: begin
          s_nxt.high_latch = s_nxt.high_latch;
        end
      endcase
    end
    // flags set by hardware win over a software clear
    if (push && s_r.sp >= SP_MAX - 5'h01) begin
      s_nxt.full = 1'b1;
    end
    if (pop && s_r.sp == 5'h00) begin
      s_nxt.under = 1'b1;
    end
    if (rd_in) begin
      unique case (addr_in)
        REG_SP: begin
          s_nxt.rdata = {s_r.full, s_r.under, 1'b0, s_r.sp};
        end
        REG_TOS_LOW: begin
          s_nxt.rdata = tos_val[7:0];
        end
        REG_TOS_HIGH: begin
          s_nxt.rdata = tos_val[15:8];
        end
        REG_TOS_UPPER: begin
          s_nxt.rdata = {3'b000, tos_val[20:16]};
        end
        REG_PC_LOW: begin
          s_nxt.rdata = s_r.pc[7:0];
          s_nxt.high_latch = s_r.pc[15:8];
          s_nxt.upper_latch = s_r.pc[20:16];
        end
        REG_PC_HIGH_LATCH: begin
          s_nxt.rdata = s_r.high_latch;
        end
        REG_PC_UPPER_LATCH: begin
          s_nxt.rdata = {3'b000, s_r.upper_latch};
        end
        default: begin
          s_nxt.rdata = 8'h00;
        end
      endcase
    end
    // device reset from a stack fault clears the pointer, keeps flags
    if (s_nxt.fault) begin
      s_nxt.sp = 5'h00;
      s_nxt.pc = RESET_VECTOR;
    end
    s_nxt.pc[0] = 1'b0;
    s_nxt.fetch = (s_r.pc > MEM_TOP) ? 16'h0000 : fetch_data_in;
  end

  // the new pointer selects the write slot ordering
  assign ram_bus.we = wentry_we;
  assign ram_bus.waddr = (wr_in && addr_in >= REG_TOS_LOW &&
    addr_in <= REG_TOS_UPPER) ? sp_new : sp_new;
  assign ram_bus.wdata = wentry;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '0;
    end else if (por_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_out = s_r.rdata;
  assign pc_out = s_r.pc;
  assign fetch_word_out = s_r.fetch;
  assign stack_reset_out = s_r.fault;
  assign restore_out = s_r.restore;
  assign status_out = s_r.status_o;
  assign working_out = s_r.working_o;
  assign bank_out = s_r.bank_o;

  property p_push_ptr;
    @(posedge mclk_in) disable iff (!resetn_in)
    (push && !pop && !wr_in && s_r.sp < 5'h1D && !por_in)
      |=> (s_r.sp == $past(s_r.sp) + 5'h01);
  endproperty
  a_push_ptr: assert property (p_push_ptr)
    else $error("push did not advance pointer");

  property p_ret_pc;
    @(posedge mclk_in) disable iff (!resetn_in)
    (is_ret && s_r.sp != 5'h00 && !wr_in && !por_in)
      |=> (s_r.pc == {$past(tos_val[20:1]), 1'b0});
  endproperty
  a_ret_pc: assert property (p_ret_pc)
    else $error("return did not load top entry");

  property p_under;
    @(posedge mclk_in) disable iff (!resetn_in)
    (pop && s_r.sp == 5'h00 && !por_in)
      |=> (s_r.under && s_r.sp == 5'h00);
  endproperty
  a_under: assert property (p_under)
    else $error("underflow not flagged");

  property p_full;
    @(posedge mclk_in) disable iff (!resetn_in)
    (push && s_r.sp == 5'h1E && !por_in) |=> s_r.full;
  endproperty
  a_full: assert property (p_full)
    else $error("full flag not set on 31st push");

  property p_hold31;
    @(posedge mclk_in) disable iff (!resetn_in)
    (push && s_r.sp == 5'h1F && !wr_in && !por_in) |=> s_r.sp == 5'h1F;
  endproperty
  a_hold31: assert property (p_hold31)
    else $error("pointer moved past 31");

  property p_fault;
    @(posedge mclk_in) disable iff (!resetn_in)
    (push && s_r.sp == 5'h1E && fault_reset_enable_in && !por_in)
      |=> (stack_reset_out && s_r.sp == 5'h00 && s_r.full);
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault reset not taken");

  property p_int_vec;
    @(posedge mclk_in) disable iff (!resetn_in)
    (op_in == OP_INT_HIGH && !wr_in && !por_in && !s_nxt.fault)
      |=> (pc_out == HIGH_VECTOR && s_r.sh_working == $past(working_in));
  endproperty
  a_int_vec: assert property (p_int_vec)
    else $error("interrupt entry wrong");

  property p_lsb;
    @(posedge mclk_in) disable iff (!resetn_in)
    (op_in == OP_STEP && !wr_in && !por_in)
      |=> (pc_out == $past(pc_out) + PC_STEP && pc_out[0] == 1'b0);
  endproperty
  a_lsb: assert property (p_lsb)
    else $error("counter bit 0 set");

  property p_latch;
    @(posedge mclk_in) disable iff (!resetn_in)
    (is_call && !wr_in && !rd_in && !por_in)
      |=> $stable(s_r.high_latch) && $stable(s_r.upper_latch);
  endproperty
  a_latch: assert property (p_latch)
    else $error("call changed latches");
endmodule

// ### testbench/core_model.sv
// sequencer and program memory model driving the counter block
module core_model
  import pcstack_pkg::*;
(
  input wire logic mclk_in,
  input wire logic [20:0] pc_in,
  output logic [3:0] op_out,
  output logic [20:0] target_out,
  output logic fast_out,
  output logic [7:0] status_out,
  output logic [7:0] working_out,
  output logic [7:0] bank_out,
  output logic [15:0] fetch_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    op_out = OP_NONE;
    target_out = 21'h000000;
    fast_out = 1'b0;
    status_out = 8'h00;
    working_out = 8'h00;
    bank_out = 8'h00;
  end
  // memory word follows the address
  assign fetch_data_out = {4'hA, pc_in[11:0]};
  // one operation, held for exactly one edge
  task automatic issue(input logic [3:0] o, input logic [20:0] t,
    input logic f);
    @(posedge mclk_in);
    op_out <= o;
    target_out <= t;
    fast_out <= f;
    @(posedge mclk_in);
    op_out <= OP_NONE;
    fast_out <= 1'b0;
  endtask
  task automatic live(input logic [7:0] s, input logic [7:0] w,
    input logic [7:0] b);
    @(posedge mclk_in);
    status_out <= s;
    working_out <= w;
    bank_out <= b;
  endtask
endmodule

// ### testbench/tb.sv
// self-checking bench for the counter and return stack
module tb;
  import pcstack_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [20:0] TOP = 21'h0000FF;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic por_in = 1'b0;
  logic fault_reset_enable_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [3:0] op;
  logic [20:0] target, pc;
  logic fast, rst_req, restore;
  logic [7:0] st, wk, bk, rdata, sh_st, sh_wk, sh_bk, cap_st, cap_wk, cap_bk;
  logic [15:0] fetch, word;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_rst = 0;
  int n_restore = 0;
  int k;

  always #12.5 mclk_in = ~mclk_in;

  core_model i_core (.mclk_in(mclk_in), .pc_in(pc), .op_out(op),
    .target_out(target), .fast_out(fast), .status_out(st),
    .working_out(wk), .bank_out(bk), .fetch_data_out(fetch));

  pc_return_stack #(.MEM_TOP(TOP)) i_dut (.mclk_in(mclk_in),
    .resetn_in(resetn_in), .por_in(por_in),
    .fault_reset_enable_in(fault_reset_enable_in), .op_in(op),
    .target_in(target), .fast_in(fast), .status_in(st),
    .working_in(wk), .bank_in(bk), .fetch_data_in(fetch),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata), .pc_out(pc),
    .fetch_word_out(word), .stack_reset_out(rst_req),
    .restore_out(restore), .status_out(sh_st), .working_out(sh_wk),
    .bank_out(sh_bk));

  // pulse counters and hang guard
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (rst_req === 1'b1) n_rst <= n_rst + 1;
    if (restore === 1'b1) begin
      n_restore <= n_restore + 1;
      cap_st <= sh_st;
      cap_wk <= sh_wk;
      cap_bk <= sh_bk;
    end
    if (cycles == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    #1;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic op_do(input logic [3:0] o, input logic [20:0] t,
    input logic f);
    i_core.issue(o, t, f);
    #1;
  endtask

  task automatic t_reset;
    chk(pc, RESET_VECTOR);
    rchk(REG_SP, SP_REG_RESET);
    rchk(4'hF, 8'h00);
  endtask

  task automatic t_call;
    wr(REG_PC_HIGH_LATCH, 8'h12);
    wr(REG_PC_UPPER_LATCH, 8'h03);
    op_do(OP_STEP, 21'h000000, 1'b0);
    chk(pc, PC_STEP);
    op_do(OP_CALL, 21'h000400, 1'b0);
    chk(pc, 21'h000400);
    rchk(REG_SP, 8'h01);
    rchk(REG_TOS_LOW, 8'h02);
    wr(REG_TOS_LOW, 8'h20);
    op_do(OP_RETURN, 21'h000000, 1'b0);
    chk(pc, 21'h000020);
    rchk(REG_SP, 8'h00);
    rchk(REG_PC_HIGH_LATCH, 8'h12);
  endtask

  task automatic t_pcl;
    rchk(REG_PC_LOW, 8'h20);
    rchk(REG_PC_UPPER_LATCH, 8'h00);
    wr(REG_PC_HIGH_LATCH, 8'h34);
    wr(REG_PC_UPPER_LATCH, 8'h01);
    wr(REG_PC_LOW, 8'h56);
    chk(pc, 21'h013456);
  endtask

  task automatic t_int;
    i_core.live(8'h11, 8'h22, 8'h33);
    op_do(OP_INT_HIGH, 21'h000000, 1'b0);
    chk(pc, HIGH_VECTOR);
    i_core.live(8'h44, 8'h55, 8'h66);
    op_do(OP_INT_LOW, 21'h000000, 1'b0);
    chk(pc, LOW_VECTOR);
    rchk(REG_SP, 8'h02);
    i_core.live(8'h00, 8'h00, 8'h00);
    op_do(OP_RETURN, 21'h000000, 1'b1);
    repeat (3) @(posedge mclk_in);
    chk(cap_st, 8'h44);
    chk(n_restore, 1);
    chk(pc, HIGH_VECTOR);
    i_core.live(8'h77, 8'h88, 8'h99);
    op_do(OP_CALL, 21'h000100, 1'b1);
    i_core.live(8'h00, 8'h00, 8'h00);
    op_do(OP_RETURN, 21'h000000, 1'b1);
    repeat (3) @(posedge mclk_in);
    chk(cap_wk, 8'h88);
    chk(cap_bk, 8'h99);
    op_do(OP_RETURN, 21'h000000, 1'b0);
    chk(pc, 21'h013456);
  endtask

  task automatic t_under;
    op_do(OP_RETURN, 21'h000000, 1'b0);
    chk(pc, RESET_VECTOR);
    rchk(REG_SP, 8'h40);
    chk(n_rst, 0);
    wr(REG_SP, 8'h00);
    rchk(REG_SP, 8'h00);
    @(posedge mclk_in);
    fault_reset_enable_in <= 1'b1;
    op_do(OP_RETURN, 21'h000000, 1'b0);
    repeat (2) @(posedge mclk_in);
    chk(n_rst, 1);
    rchk(REG_SP, 8'h40);
    wr(REG_SP, 8'h00);
  endtask

  task automatic t_full(input logic en, input logic [7:0] sp_exp);
    @(posedge mclk_in);
    fault_reset_enable_in <= en;
    k = n_rst;
    op_do(OP_JUMP, 21'h000200, 1'b0);
    repeat (31) op_do(OP_PUSH, 21'h000000, 1'b0);
    rchk(REG_SP, sp_exp);
    chk(pc, en ? RESET_VECTOR : 21'h00023E);
    chk(n_rst - k, en);
    wr(REG_SP, 8'h9F);
    rchk(REG_TOS_LOW, {6'h0F, en, 1'b0});
    rchk(REG_TOS_HIGH, 8'h02);
    if (!en) begin
      op_do(OP_STEP, 21'h000000, 1'b0);
      op_do(OP_PUSH, 21'h000000, 1'b0);
      rchk(REG_SP, 8'h9F);
      rchk(REG_TOS_LOW, 8'h3C);
    end
    op_do(OP_POP, 21'h000000, 1'b0);
    rchk(REG_SP, 8'h9E);
    @(posedge mclk_in);
    por_in <= 1'b1;
    @(posedge mclk_in);
    por_in <= 1'b0;
    rchk(REG_SP, 8'h00);
  endtask

  task automatic t_fetch;
    op_do(OP_JUMP, TOP + 21'h000001, 1'b0);
    repeat (3) @(posedge mclk_in);
    chk(word, 16'h0000);
    op_do(OP_JUMP, 21'h0000FE, 1'b0);
    repeat (3) @(posedge mclk_in);
    chk(word, 16'hA0FE);
  endtask

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    t_reset();
    t_call();
    t_pcl();
    t_int();
    t_under();
    t_full(1'b0, 8'h9F);
    t_full(1'b1, 8'h80);
    t_fetch();
    wrap_up();
  end
endmodule
